// *** inc/rxwb_pkg.sv ***
/*
 Shared constants of the receive status write-back block:
 status word layout, register offsets, event bits.
 Assumes a 32-bit AHB-Lite register bus.
*/
package rxwb_pkg;
    localparam int OWN_B = 31;
    localparam int FF_B = 30;
    localparam int LEN_HI = 29;
    localparam int LEN_LO = 16;
    localparam int LEN_W = 14;
    localparam int ES_B = 15;
    localparam int TRUNC_B = 14;
    localparam int SRC_HI = 13;
    localparam int SRC_LO = 12;
    localparam int RUNT_B = 11;
    localparam int FIRST_B = 9;
    localparam int FINAL_B = 8;
    localparam int LONG_B = 7;
    localparam int COLL_B = 6;
    localparam int CRC_B = 1;
    localparam int MODE_RA_B = 30;
    localparam int MODE_HI = 11;
    localparam int MODE_LO = 10;
    localparam int MODE_PB_B = 3;
    localparam logic [13:0] MIN_FF_LEN = 14'h0040;
    localparam logic [1:0] SRC_LINE = 2'h0;
    localparam logic [1:0] SRC_INT_LB = 2'h1;
    localparam logic [1:0] SRC_EXT_LB = 2'h2;
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_LAST = 8'h04;
    localparam logic [7:0] A_ISTAT = 8'h08;
    localparam logic [7:0] A_IMASK = 8'h0C;
    localparam logic [31:0] MODE_MASK = 32'h4000_0C08;
    localparam int EV_W = 4;
    localparam int EV_DONE = 0;
    localparam int EV_TRUNC = 1;
    localparam int EV_DROP = 2;
    localparam int EV_NODESC = 3;
    localparam logic [1:0] HT_NONSEQ = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RUN, ST_WAIT, ST_DISCARD, ST_WRITE
    } rxwb_state_t;
endpackage

// *** core/rxwb_core.sv ***
/*
 Receive descriptor status word builder and write-back engine,
 with AHB-Lite registers and a masked interrupt.
 Assumes receive path strobes on the same clock and a
 write-back port held until the memory side accepts the word.
*/
// Added by the designer: the register addresses and the AHB-Lite register port.
// Behaviour
// - Own descriptor only while ownership bit set
// - Clear ownership on frame end or full; a runt frame dropped without pass-bad writes no word back
// - Filter fail only with receive-all on
// - Filter fail final descriptor, 64+ bytes
// - Length counts bytes moved, CRC included
// - Length valid final, truncation clear only; the truncated final word also carries cnt_r
// - Time-out reports only transferred byte count
// - Error summary ORs crc/coll/long/runt/trunc
// - Summary and truncation only in final
// - Overflow without next descriptor truncates frame
// - Source code 00 line, 01/10 loopback
// - Source code taken from operating mode
// - Final-buffer bit set at frame end
// - Runt frames kept only with pass-bad
`timescale 1ns/1ps
module rxwb_core
    import rxwb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic desc_load,
    input wire logic desc_own,
    input wire logic next_own,
    input wire logic byte_stb,
    input wire logic buf_full,
    input wire logic frame_end,
    input wire logic err_crc,
    input wire logic err_coll,
    input wire logic err_long,
    input wire logic err_runt,
    input wire logic addr_fail,
    input wire logic rx_timeout,
    input wire logic [11:0] misc_bits,
    output logic wb_valid,
    output logic [31:0] wb_word,
    input wire logic wb_ready,
    output logic irq
);
    function automatic logic [1:0] src_code(input logic [1:0] m);
        case (m)
            2'h1: src_code = SRC_INT_LB;
            2'h2: src_code = SRC_EXT_LB;
            default: src_code = SRC_LINE;
        endcase
    endfunction

    rxwb_state_t state_r;
    rxwb_state_t after_r;
    logic [31:0] mode_r;
    logic [31:0] last_r;
    logic [EV_W-1:0] istat_r;
    logic [EV_W-1:0] imask_r;
    logic [LEN_W-1:0] cnt_r;
    logic first_r;
    logic [31:0] wb_word_r;
    logic [EV_W-1:0] ev;
    logic [7:0] a_addr_r;
    logic a_wr_r;
    logic [31:0] hrdata_r;
    logic [1:0] src;
    logic ff_ok;
    logic drop;
    logic [31:0] fin_word;
    logic [31:0] mid_word;
    logic [31:0] trunc_word;
    logic a_phase;

    assign src = src_code(mode_r[MODE_HI:MODE_LO]);
    assign ff_ok = mode_r[MODE_RA_B] && addr_fail && (cnt_r >= MIN_FF_LEN);
    assign drop = err_runt && !mode_r[MODE_PB_B];

    always_comb begin
        fin_word = {20'h0_0000, misc_bits};
        fin_word[OWN_B] = 1'b0;
        fin_word[FF_B] = ff_ok;
        fin_word[LEN_HI:LEN_LO] = cnt_r;
        fin_word[ES_B] = err_crc | err_coll | err_long | err_runt;
        fin_word[TRUNC_B] = 1'b0;
        fin_word[SRC_HI:SRC_LO] = src;
        fin_word[RUNT_B] = err_runt;
        fin_word[FIRST_B] = first_r;
        fin_word[FINAL_B] = 1'b1;
        fin_word[LONG_B] = err_long;
        fin_word[COLL_B] = err_coll;
        fin_word[CRC_B] = err_crc;
    end

    always_comb begin
        mid_word = 32'h0000_0000;
        mid_word[SRC_HI:SRC_LO] = src;
        mid_word[FIRST_B] = first_r;
        trunc_word = mid_word;
        trunc_word[FINAL_B] = 1'b1;
        trunc_word[TRUNC_B] = 1'b1;
        trunc_word[ES_B] = 1'b1;
        trunc_word[LEN_HI:LEN_LO] = cnt_r;
    end

    always_comb begin
        ev = '0;
        if (state_r == ST_WRITE && wb_ready && after_r == ST_IDLE) begin
            ev[EV_DONE] = 1'b1;
        end
        if (state_r == ST_RUN && buf_full && !frame_end && !next_own) begin
            ev[EV_TRUNC] = 1'b1;
        end
        if (state_r == ST_RUN && frame_end && drop) begin
            ev[EV_DROP] = 1'b1;
        end
        if ((state_r == ST_IDLE || state_r == ST_WAIT) && desc_load && !desc_own) begin
            ev[EV_NODESC] = 1'b1;
        end
    end

    // Descriptor sequencing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            after_r <= ST_IDLE;
            wb_word_r <= 32'h0000_0000;
            first_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (desc_load && desc_own) begin
                        state_r <= ST_RUN;
                        first_r <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (frame_end) begin
                        if (drop) begin
                            state_r <= ST_IDLE;
                        end else begin
                            wb_word_r <= fin_word;
                            after_r <= ST_IDLE;
                            state_r <= ST_WRITE;
                        end
                    end else if (buf_full) begin
                        state_r <= ST_WRITE;
                        if (next_own) begin
                            wb_word_r <= mid_word;
                            after_r <= ST_WAIT;
                        end else begin
                            wb_word_r <= trunc_word;
                            after_r <= ST_DISCARD;
                        end
                    end
                end
                ST_WAIT: begin
                    if (desc_load) begin
                        state_r <= desc_own ? ST_RUN : ST_DISCARD;
                        first_r <= 1'b0;
                    end
                end
                ST_DISCARD: begin
                    if (frame_end) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (wb_ready) begin
                        state_r <= after_r;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Transferred byte count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (state_r == ST_IDLE) begin
            cnt_r <= '0;
        end else if (state_r == ST_RUN && byte_stb && !(&cnt_r)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign wb_valid = (state_r == ST_WRITE);
    assign wb_word = wb_word_r;

    // Last word written back
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_r <= 32'h0000_0000;
        end else if (wb_valid && wb_ready) begin
            last_r <= wb_word_r;
        end
    end

    // Bus address phase capture
    assign a_phase = hsel && hready && htrans == HT_NONSEQ;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            a_addr_r <= 8'h00;
            a_wr_r <= 1'b0;
        end else begin
            a_wr_r <= a_phase && hwrite;
            if (a_phase) begin
                a_addr_r <= haddr[7:0];
            end
        end
    end

    // Read data for the data phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (a_phase && !hwrite) begin
            case (haddr[7:0])
                A_MODE: hrdata_r <= mode_r;
                A_LAST: hrdata_r <= last_r;
                A_ISTAT: hrdata_r <= {{(32-EV_W){1'b0}}, istat_r};
                A_IMASK: hrdata_r <= {{(32-EV_W){1'b0}}, imask_r};
                default: hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Configuration registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_r <= 32'h0000_0000;
            imask_r <= '0;
        end else if (a_wr_r) begin
            if (a_addr_r == A_MODE) begin
                mode_r <= hwdata & MODE_MASK;
            end
            if (a_addr_r == A_IMASK) begin
                imask_r <= hwdata[EV_W-1:0];
            end
        end
    end

    // Sticky events, set wins over clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            istat_r <= '0;
        end else begin
            for (int i = 0; i < EV_W; i++) begin
                if (ev[i]) begin
                    istat_r[i] <= 1'b1;
                end else if (a_wr_r && a_addr_r == A_ISTAT && hwdata[i]) begin
                    istat_r[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(istat_r & imask_r);

    a_own_cleared: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid |-> !wb_word[OWN_B])
        else $error("ownership not returned");
    a_ff_needs_ra: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && wb_word[FF_B] |-> mode_r[MODE_RA_B])
        else $error("filter fail without receive-all");
    a_ff_len_min: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && wb_word[FF_B] |-> wb_word[FINAL_B] && wb_word[LEN_HI:LEN_LO] >= MIN_FF_LEN)
        else $error("filter fail on short or mid word");
    a_es_or: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && wb_word[FINAL_B] |-> wb_word[ES_B] == (wb_word[CRC_B] | wb_word[COLL_B]
        | wb_word[LONG_B] | wb_word[RUNT_B] | wb_word[TRUNC_B]))
        else $error("error summary mismatch");
    a_mid_clean: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && !wb_word[FINAL_B] |-> !wb_word[ES_B] && !wb_word[TRUNC_B])
        else $error("error flags in mid word");
    a_trunc_next: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && buf_full && !frame_end && !next_own
        |=> wb_valid && wb_word[TRUNC_B] && wb_word[FINAL_B])
        else $error("truncation not reported");
    a_src_mode: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && $stable(mode_r) |-> wb_word[SRC_HI:SRC_LO] == src_code(mode_r[MODE_HI:MODE_LO]))
        else $error("source code not from mode");
    a_final_end: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && frame_end && !drop |=> wb_valid && wb_word[FINAL_B])
        else $error("final bit missing at frame end");
    a_runt_drop: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && frame_end && drop |=> state_r == ST_IDLE && !wb_valid)
        else $error("runt frame delivered");
    a_own_gate: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_IDLE && desc_load && !desc_own |=> state_r == ST_IDLE)
        else $error("host descriptor taken");
    a_run_take: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_IDLE && desc_load && desc_own |=> state_r == ST_RUN)
        else $error("owned descriptor not taken");
    a_wait_discard: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_WAIT && desc_load && !desc_own |=> state_r == ST_DISCARD)
        else $error("host descriptor used mid frame");
    a_buf_mid: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && buf_full && !frame_end && next_own
        |=> wb_valid && !wb_word[OWN_B] && !wb_word[FINAL_B])
        else $error("full buffer not handed back");
    a_wb_hold: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && !wb_ready |=> wb_valid && $stable(wb_word))
        else $error("status word dropped while stalled");
    a_ff_off: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && frame_end && !drop && !mode_r[MODE_RA_B] |=> !wb_word[FF_B])
        else $error("filter fail set with receive-all off");
    a_cnt_idle: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_IDLE |=> cnt_r == '0)
        else $error("byte count not cleared");
    a_cnt_step: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && byte_stb && !(&cnt_r) |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("byte not counted");
    a_final_len: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && frame_end && !drop |=> wb_word[LEN_HI:LEN_LO] == $past(cnt_r))
        else $error("length not transferred count");
    a_mid_len: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && !wb_word[FINAL_B] |-> wb_word[LEN_HI:LEN_LO] == '0)
        else $error("length in mid word");
    a_timeout_len: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && frame_end && rx_timeout && !drop
        |=> wb_valid && wb_word[LEN_HI:LEN_LO] == $past(cnt_r))
        else $error("time-out length wrong");
    a_trunc_final: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid && wb_word[TRUNC_B] |-> wb_word[FINAL_B] && wb_word[ES_B])
        else $error("truncation outside final word");
    a_src_legal: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid |-> wb_word[SRC_HI:SRC_LO] == SRC_LINE || wb_word[SRC_HI:SRC_LO] == SRC_INT_LB
        || wb_word[SRC_HI:SRC_LO] == SRC_EXT_LB)
        else $error("reserved source code");
    a_runt_keep: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == ST_RUN && frame_end && err_runt && mode_r[MODE_PB_B] |=> wb_valid && wb_word[RUNT_B])
        else $error("runt frame not kept");
endmodule

// *** testbench/rxwb_host_model.sv ***
/*
 Host-side model that takes written-back status words.
 Assumes one clock and the write-back valid/ready handshake.
*/
`timescale 1ns/1ps
module rxwb_host_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stall_en,
    input wire logic wb_valid,
    input wire logic [31:0] wb_word,
    output logic wb_ready,
    output logic got_stb,
    output logic [31:0] got_word
);
    // Word captured every cycle, strobe only when handed back; never altered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ready <= 1'b0;
            got_stb <= 1'b0;
            got_word <= 32'h0000_0000;
        end else begin
            wb_ready <= stall_en ? 1'($urandom % 2) : 1'b1;
            got_stb <= wb_valid & wb_ready;
            got_word <= wb_word;
        end
    end
endmodule

// *** testbench/rxwb_core_bench.sv ***
/*
 Self-checking bench of the receive status write-back block.
 Assumes the shared package and the host model.
*/
`timescale 1ns/1ps
module rxwb_core_bench;
    import rxwb_pkg::*;
    logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, wb_word, got_word, rd, last_w, em;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic desc_load = 0, desc_own = 0, next_own = 0, byte_stb = 0, buf_full = 0, frame_end = 0;
    logic err_crc = 0, err_coll = 0, err_long = 0, err_runt = 0, addr_fail = 0, rx_timeout = 0;
    logic [11:0] misc_bits = '0;
    logic wb_valid, wb_ready, got_stb, stall_en = 0, own2 = 1;
    int error_cnt = 0, samples_checked = 0, cyc = 0, got_n = 0, ra, pb, md;
    logic [31:0] exp_w[$], exp_m[$];
    rxwb_core rxwb_core_i (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .desc_load(desc_load), .desc_own(desc_own), .next_own(next_own), .byte_stb(byte_stb),
        .buf_full(buf_full), .frame_end(frame_end), .err_crc(err_crc), .err_coll(err_coll),
        .err_long(err_long), .err_runt(err_runt), .addr_fail(addr_fail), .rx_timeout(rx_timeout),
        .misc_bits(misc_bits), .wb_valid(wb_valid), .wb_word(wb_word), .wb_ready(wb_ready), .irq(irq)
    );
    rxwb_host_model rxwb_host_model_i (
        .clk_sys(clk_sys), .rst(rst), .stall_en(stall_en), .wb_valid(wb_valid), .wb_word(wb_word),
        .wb_ready(wb_ready), .got_stb(got_stb), .got_word(got_word)
    );
    assign hready = hreadyout;
    always #10 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", nm, e, s);
            error_cnt++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    always @(negedge clk_sys) begin
        if (got_stb === 1'b1) begin
            got_n++;
            if (exp_w.size() == 0) begin
                chk("extra word", 32'h0000_0000, 32'h0000_0001);
            end else begin
                em = exp_m.pop_front();
                chk("status word", exp_w.pop_front() & em, got_word & em);
            end
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HT_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do tick(); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do tick(); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic setm(input int r, input int p, input int m);
        ra = r;
        pb = p;
        md = m;
        ahb(1'b1, A_MODE, 32'(r << 30 | p << 3 | m << 10));
    endtask
    function automatic logic [1:0] src();
        return (md == 3) ? 2'h0 : 2'(md);
    endfunction
    function automatic logic [31:0] fw(int n, logic [4:0] er, logic first, logic [11:0] mb);
        logic [31:0] w;
        w = '0;
        w[FF_B] = er[4] & ra[0];
        w[LEN_HI:LEN_LO] = n[13:0];
        w[ES_B] = |er[3:0];
        w[SRC_HI:SRC_LO] = src();
        w[11:0] = (mb & 12'h43D) | {er[3], 1'b0, first, 1'b1, er[2:1], 4'h0, er[0], 1'b0};
        return w;
    endfunction
    task automatic wait_wb(input int k);
        for (int t = 0; t < 300 && got_n < k; t++) tick();
        chk("word count", 32'(k), 32'(got_n));
    endtask
    // er holds filter fail, runt, long, collision, crc
    task automatic frame(input int n, input int sp, input logic nxt, input logic [4:0] er);
        logic [11:0] mb;
        int k;
        mb = 12'($urandom);
        k = got_n;
        desc_load <= 1'b1;
        desc_own <= 1'b1;
        tick();
        desc_load <= 1'b0;
        for (int i = 0; i < n; i++) begin
            if (i == sp) begin
                byte_stb <= 1'b0;
                buf_full <= 1'b1;
                next_own <= nxt;
                exp_w.push_back(nxt ? {18'h0_0000, src(), 12'h200} : {16'h0000, 2'b11, src(), 12'h100});
                exp_m.push_back(nxt ? 32'h8000_3300 : 32'h8000_F100);
                tick();
                buf_full <= 1'b0;
                wait_wb(++k);
                if (nxt) begin
                    desc_load <= 1'b1;
                    desc_own <= own2;
                    tick();
                    desc_load <= 1'b0;
                end
            end
            byte_stb <= 1'b1;
            tick();
        end
        byte_stb <= 1'b0;
        frame_end <= 1'b1;
        {addr_fail, err_runt, err_long, err_coll, err_crc} <= er;
        rx_timeout <= 1'($urandom);
        misc_bits <= mb;
        tick();
        frame_end <= 1'b0;
        {addr_fail, err_runt, err_long, err_coll, err_crc} <= 5'h00;
        if (!(sp >= 0 && !(nxt && own2)) && !(er[3] && pb == 0)) begin
            last_w = fw(n, er, sp < 0, mb);
            exp_w.push_back(last_w);
            exp_m.push_back(n < 64 ? 32'hBFFF_FFFF : 32'hFFFF_FFFF);
            k++;
        end
        tick(4);
        wait_wb(k);
    endtask
    initial begin
        void'($urandom(27331));
        tick(2);
        rst <= 1'b0;
        tick();
        chk("reset outputs", 32'h0000_0000, {29'h0, hresp, wb_valid, irq});
        ahb(1'b1, A_MODE, 32'hFFFF_FFFF);
        ahb(1'b0, A_MODE, 32'h0000_0000);
        chk("mode reg", MODE_MASK, rd);
        ahb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        for (int m = 0; m < 4; m++) begin
            setm(1, 1, m);
            frame(70, -1, 1'b0, 5'h10);
            ahb(1'b0, A_LAST, 32'h0000_0000);
            chk("last word", last_w, rd);
        end
        $display("test source codes done");
        stall_en <= 1'b1;
        repeat (8) begin
            setm($urandom % 2, 1, $urandom % 4);
            frame(20 + $urandom % 300, -1, 1'b0, 5'($urandom));
        end
        frame(64, -1, 1'b0, 5'h10);
        $display("test random frames done");
        frame(100, 40, 1'b1, 5'h01);
        $display("test chained frame done");
        ahb(1'b1, A_ISTAT, 32'h0000_000F);
        frame(90, 30, 1'b0, 5'h00);
        ahb(1'b0, A_ISTAT, 32'h0000_0000);
        chk("trunc event", 32'h0000_0002, rd & 32'h0000_0002);
        $display("test truncation done");
        setm(0, 0, 0);
        frame(40, -1, 1'b0, 5'h08);
        own2 = 1'b0;
        frame(60, 20, 1'b1, 5'h00);
        own2 = 1'b1;
        desc_load <= 1'b1;
        desc_own <= 1'b0;
        tick();
        desc_load <= 1'b0;
        tick(3);
        ahb(1'b0, A_ISTAT, 32'h0000_0000);
        chk("drop events", 32'h0000_000C, rd & 32'h0000_000C);
        $display("test drops done");
        ahb(1'b1, A_ISTAT, 32'h0000_000F);
        ahb(1'b1, A_IMASK, 32'h0000_0000);
        frame(80, -1, 1'b0, 5'h00);
        ahb(1'b0, A_ISTAT, 32'h0000_0000);
        chk("done event", 32'h0000_0001, rd & 32'h0000_000F);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        ahb(1'b1, A_IMASK, 32'h0000_0001);
        tick();
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        ahb(1'b1, A_ISTAT, 32'h0000_0001);
        tick();
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule
